// ==== include/fbep_pkg.sv ====
// Purpose: Shared constants and types of the flash block erase and protection checker
// Assumes: 32-bit flash words, word-aligned byte addresses
// Notes: Protection codes arrive as two bits per protection unit
//
// Overview of operation
// - Flash array holds 16 KB in total
// - Each 1 KB block erases on its own
// - Erased block reads back as all ones
// - Block pairs form 2 KB protection units
// - Unit is open, read-only or execute-only
// - Read-only unit refuses erase and program
// - Execute-only unit refuses erase and program
// - Execute-only unit serves instruction fetches only
package fbep_pkg;

	// Array geometry
	localparam int FLASH_BYTES = 16384;
	localparam int ERASE_BYTES = 1024;
	localparam int PROT_BYTES = 2048;
	localparam int WORD_BYTES = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = $clog2(FLASH_BYTES);
	localparam int WADDR_W = $clog2(FLASH_BYTES / WORD_BYTES);
	localparam int FLASH_WORDS = FLASH_BYTES / WORD_BYTES;
	localparam int ECNT_W = $clog2(ERASE_BYTES / WORD_BYTES);
	localparam int EBLK_W = WADDR_W - ECNT_W;
	localparam int UNIT_LSB = $clog2(PROT_BYTES / WORD_BYTES);
	localparam int N_UNITS = FLASH_BYTES / PROT_BYTES;
	localparam int UNIT_W = $clog2(N_UNITS);

	// Erase fill and last erase word index
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [ECNT_W-1:0] ECNT_LAST = 8'hFF;

	// Protection codes per unit
	localparam logic [1:0] PROT_OPEN = 2'h0;
	localparam logic [1:0] PROT_RO = 2'h1;
	localparam logic [1:0] PROT_XO = 2'h2;

	// Request kinds
	localparam logic [2:0] KIND_FETCH = 3'h0;
	localparam logic [2:0] KIND_DATA = 3'h1;
	localparam logic [2:0] KIND_DEBUG = 3'h2;
	localparam logic [2:0] KIND_PROG = 3'h3;
	localparam logic [2:0] KIND_ERASE = 3'h4;

	// Controller states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHECK,
		ST_READ,
		ST_ERASE
	} fbep_state_t;

endpackage

// ==== include/fbep_mem_if.sv ====
// Purpose: Link between the checker and its flash array
// Assumes: One access per cycle, read data registered in the array
// Notes: Strobes are driven combinationally by the checker
`timescale 1ns/1ps
interface fbep_mem_if;
	logic rd_en; // Read strobe
	logic wr_en; // Write strobe
	logic [fbep_pkg::WADDR_W-1:0] addr; // Word address
	logic [fbep_pkg::DATA_W-1:0] wdata; // Write data
	logic [fbep_pkg::DATA_W-1:0] rdata; // Registered read data

	modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
	modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// ==== verilog/fbep_mem.sv ====
// Purpose: Flash word array with registered read data
// Assumes: Single port, write and read never in the same cycle
// Notes: Contents are not reset, as in a non-volatile array
`timescale 1ns/1ps
module fbep_mem (
	input wire logic ref_clk,
	input wire logic arst_n,
	fbep_mem_if.mem port
);

	// Whole 16 KB array as words
	logic [fbep_pkg::DATA_W-1:0] store [fbep_pkg::FLASH_WORDS];
	logic [fbep_pkg::DATA_W-1:0] rdata_reg; // Read data register

	// Array write, no reset on storage
	always_ff @(posedge ref_clk) begin
		if (port.wr_en) begin
			store[port.addr] <= port.wdata;
		end
	end

	// Registered read port
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 32'h00000000;
		end else if (port.rd_en) begin
			rdata_reg <= store[port.addr];
		end
	end

	assign port.rdata = rdata_reg;

endmodule

// ==== verilog/fbep_top.sv ====
// Purpose: Access checker and erase sequencer for the flash array
// Assumes: Requesters and protection settings share ref_clk
// Notes: One request in flight; req_ready drops while busy
`timescale 1ns/1ps
module fbep_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic [13:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [15:0] prot_mode,
	output logic rsp_valid,
	output logic rsp_denied,
	output logic [31:0] rsp_rdata
);

	fbep_pkg::fbep_state_t state_reg; // Controller state
	fbep_pkg::fbep_state_t state_next; // Next controller state
	logic [2:0] kind_reg; // Latched request kind
	logic [fbep_pkg::WADDR_W-1:0] waddr_reg; // Latched word address
	logic [fbep_pkg::DATA_W-1:0] wdata_reg; // Latched program data
	logic [fbep_pkg::ECNT_W-1:0] ecnt_reg; // Erase word counter
	logic ready_reg; // Request acceptance flag
	logic rsp_valid_reg; // Response pulse
	logic rsp_denied_reg; // Response refused flag
	logic [fbep_pkg::DATA_W-1:0] rsp_rdata_reg; // Response data
	logic [fbep_pkg::N_UNITS-1:0] unit_ro; // Read-only flag per unit
	logic [fbep_pkg::N_UNITS-1:0] unit_xo; // Execute-only flag per unit
	logic [fbep_pkg::UNIT_W-1:0] unit_sel; // Unit owning the latched address
	logic sel_ro; // Owning unit is read-only
	logic sel_xo; // Owning unit is execute-only
	logic is_read; // Latched request is a read
	logic allow; // Latched request passes protection
	logic accept; // Request taken this cycle
	logic erase_last; // Final word of an erase

	fbep_mem_if mem_link ();

	// Flash array instance
	fbep_mem u_mem (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.port(mem_link.mem)
	);

	// Decode protection code of every unit
	generate
		for (genvar u = 0; u < fbep_pkg::N_UNITS; u++) begin : g_unit
			// Unused code 3 treated as the strictest setting
			assign unit_ro[u] = (prot_mode[2*u +: 2] == fbep_pkg::PROT_RO);
			assign unit_xo[u] = (prot_mode[2*u +: 2] == fbep_pkg::PROT_XO) ||
				(prot_mode[2*u +: 2] == 2'h3);
		end
	endgenerate

	// Both 1 KB halves share their 2 KB unit
	assign unit_sel = waddr_reg[fbep_pkg::WADDR_W-1:fbep_pkg::UNIT_LSB];
	assign sel_ro = unit_ro[unit_sel];
	assign sel_xo = unit_xo[unit_sel];
	assign accept = req_valid && ready_reg;
	assign erase_last = (ecnt_reg == fbep_pkg::ECNT_LAST);

	// Classify the latched request
	always_comb begin
		is_read = 1'b0;
		allow = 1'b0;
		case (kind_reg)
			fbep_pkg::KIND_FETCH: begin
				// Instruction fetches pass every setting
				is_read = 1'b1;
				allow = 1'b1;
			end
			fbep_pkg::KIND_DATA, fbep_pkg::KIND_DEBUG: begin
				// Data and debugger reads blocked on execute-only
				is_read = 1'b1;
				allow = !sel_xo;
			end
			fbep_pkg::KIND_PROG, fbep_pkg::KIND_ERASE: begin
				// Changes blocked on either protected setting
				allow = !sel_ro && !sel_xo;
			end
			default: begin
				// Unknown kinds are refused
				allow = 1'b0;
			end
		endcase
	end

	// Drive the array only after the check
	always_comb begin
		mem_link.rd_en = (state_reg == fbep_pkg::ST_CHECK) && allow && is_read;
		mem_link.wr_en = ((state_reg == fbep_pkg::ST_CHECK) && allow &&
			(kind_reg == fbep_pkg::KIND_PROG)) || (state_reg == fbep_pkg::ST_ERASE);
		if (state_reg == fbep_pkg::ST_ERASE) begin
			// Sweep only the addressed 1 KB block
			mem_link.addr = {waddr_reg[fbep_pkg::WADDR_W-1:fbep_pkg::ECNT_W], ecnt_reg};
			mem_link.wdata = fbep_pkg::ERASED_WORD;
		end else begin
			// Single word access
			mem_link.addr = waddr_reg;
			mem_link.wdata = wdata_reg;
		end
	end

	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			fbep_pkg::ST_IDLE: begin
				// Wait for a request
				if (accept) begin
					state_next = fbep_pkg::ST_CHECK;
				end
			end
			fbep_pkg::ST_CHECK: begin
				// Refusals and programs finish here
				if (allow && is_read) begin
					state_next = fbep_pkg::ST_READ;
				end else if (allow && (kind_reg == fbep_pkg::KIND_ERASE)) begin
					state_next = fbep_pkg::ST_ERASE;
				end else begin
					state_next = fbep_pkg::ST_IDLE;
				end
			end
			fbep_pkg::ST_READ: begin
				// Array data captured
				state_next = fbep_pkg::ST_IDLE;
			end
			fbep_pkg::ST_ERASE: begin
				// Leave after the last word
				if (erase_last) begin
					state_next = fbep_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= fbep_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Ready follows the return to idle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= (state_next == fbep_pkg::ST_IDLE);
		end
	end

	// Latch the accepted request
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			kind_reg <= fbep_pkg::KIND_FETCH;
			waddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
		end else if (accept) begin
			// Byte lane bits are ignored
			kind_reg <= req_kind;
			waddr_reg <= req_addr[fbep_pkg::ADDR_W-1:2];
			wdata_reg <= req_wdata;
		end
	end

	// Erase word counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ecnt_reg <= 8'h00;
		end else if (state_reg == fbep_pkg::ST_ERASE) begin
			ecnt_reg <= ecnt_reg + 8'h01;
		end else begin
			ecnt_reg <= 8'h00;
		end
	end

	// Response pulse and refusal flag
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid_reg <= 1'b0;
			rsp_denied_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				fbep_pkg::ST_CHECK: begin
					// Refused or programmed requests answer now
					rsp_valid_reg <= !allow || (kind_reg == fbep_pkg::KIND_PROG);
					rsp_denied_reg <= !allow;
				end
				fbep_pkg::ST_READ: begin
					// Read answered with array data
					rsp_valid_reg <= 1'b1;
					rsp_denied_reg <= 1'b0;
				end
				fbep_pkg::ST_ERASE: begin
					// Erase answered after the sweep
					rsp_valid_reg <= erase_last;
					rsp_denied_reg <= 1'b0;
				end
				fbep_pkg::ST_IDLE: begin
					// Nothing to answer
					rsp_valid_reg <= 1'b0;
					rsp_denied_reg <= 1'b0;
				end
			endcase
		end
	end

	// Response data, zero unless a read succeeds
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_rdata_reg <= 32'h00000000;
		end else if (state_reg == fbep_pkg::ST_READ) begin
			rsp_rdata_reg <= mem_link.rdata;
		end else if (state_reg == fbep_pkg::ST_CHECK) begin
			// Denied reads never leak stale data
			rsp_rdata_reg <= 32'h00000000;
		end
	end

	assign req_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_denied = rsp_denied_reg;
	assign rsp_rdata = rsp_rdata_reg;

endmodule

// ==== verif/fbep_checker.sv ====
// Purpose: Port-level assertions for the flash access checker
// Assumes: Sees only the top module ports
// Notes: Helper flops recall the request in its check cycle
`timescale 1ns/1ps
module fbep_checker (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic [13:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [15:0] prot_mode,
	input wire logic rsp_valid,
	input wire logic rsp_denied,
	input wire logic [31:0] rsp_rdata
);
	logic tk_reg; // Request taken at last edge
	logic [2:0] kind_reg; // Its kind
	logic [2:0] unit_reg; // Its protection unit
	wire logic [1:0] pm = prot_mode[unit_reg*2 +: 2]; // Code of that unit
	wire logic wr = kind_reg == 3'h3 || kind_reg == 3'h4; // Program or erase
	wire logic rd = kind_reg == 3'h1 || kind_reg == 3'h2; // Data or debug read
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Capture the request as it is taken
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tk_reg <= 1'b0;
			kind_reg <= 3'h0;
			unit_reg <= 3'h0;
		end else begin
			tk_reg <= req_valid && req_ready;
			kind_reg <= req_kind;
			unit_reg <= req_addr[13:11];
		end
	end
	chk_ro_refuse: assert property (tk_reg && wr && pm == 2'h1 |=> rsp_valid && rsp_denied)
		else $error("write to read-only unit not refused");
	chk_xo_refuse: assert property (tk_reg && wr && pm[1] |=> rsp_valid && rsp_denied)
		else $error("write to execute-only unit not refused");
	chk_xo_read: assert property (tk_reg && rd && pm[1] |=> rsp_valid && rsp_denied && rsp_rdata == 32'h0)
		else $error("data read of execute-only unit served");
	chk_fetch_served: assert property (tk_reg && kind_reg == 3'h0 |=> !rsp_valid ##1 rsp_valid && !rsp_denied)
		else $error("fetch not served in time");
	chk_open_prog: assert property (tk_reg && kind_reg == 3'h3 && pm == 2'h0 |=> rsp_valid && !rsp_denied)
		else $error("program of open unit refused");
	chk_erase_span: assert property (tk_reg && kind_reg == 3'h4 && pm == 2'h0 |-> ##257 rsp_valid && !rsp_denied)
		else $error("erase answer late or refused");
	chk_one_flight: assert property (req_valid && req_ready |=> !req_ready)
		else $error("second request accepted while busy");
	chk_bad_kind: assert property (tk_reg && kind_reg > 3'h4 |=> rsp_valid && rsp_denied && rsp_rdata == 32'h0)
		else $error("unknown kind not refused");
	cover property (tk_reg && kind_reg == 3'h4 && pm == 2'h0);
	cover property (tk_reg && rd && pm[1]);
	cover property (tk_reg && kind_reg > 3'h4);
endmodule
bind fbep_top fbep_checker u_fbep_checker (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
	.req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
	.prot_mode(prot_mode), .rsp_valid(rsp_valid), .rsp_denied(rsp_denied), .rsp_rdata(rsp_rdata));

// ==== verif/fbep_req_model.sv ====
// Purpose: Requester standing for fetch, data and debug paths
// Assumes: Called at a falling edge, one request at a time
// Notes: Released address and data show inverted values
`timescale 1ns/1ps
module fbep_req_model (
	input wire logic ref_clk,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic rsp_denied,
	input wire logic [31:0] rsp_rdata,
	output logic req_valid,
	output logic [2:0] req_kind,
	output logic [13:0] req_addr,
	output logic [31:0] req_wdata
);
	// Idle values at time zero
	initial begin
		req_valid = 1'b0;
		req_kind = 3'h0;
		req_addr = 14'h0;
		req_wdata = 32'h0;
	end
	// Hold the request until taken, then wait for its answer
	task automatic issue(input logic [2:0] k, input logic [13:0] a, input logic [31:0] d,
		output logic den, output logic [31:0] rd);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_kind = k;
		req_addr = a;
		req_wdata = d;
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		req_addr = ~a;
		req_wdata = ~d;
		while (rsp_valid !== 1'b1 && n < 800) begin
			@(negedge ref_clk);
			n++;
		end
		// A missing answer shows as unknown so that the compare counts it
		den = (rsp_valid === 1'b1) ? rsp_denied : 1'bx;
		rd = rsp_rdata;
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the flash access checker
// Assumes: Word model kept in an associative array
// Notes: Unknown words are not compared on read
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, arst_n, req_valid, req_ready, rsp_valid, rsp_denied, den;
	logic [2:0] req_kind;
	logic [13:0] req_addr;
	logic [31:0] req_wdata, rsp_rdata, rd;
	logic [15:0] prot_mode;
	logic [13:0] ra; // Random request address, kept apart from the model's driven bus
	logic [15:0] lfsr = 16'h0041; // Random source
	logic [31:0] mem [int]; // Model of known words
	int n_mismatch = 0;
	int n_checks = 0;
	fbep_top u_fbep_top (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .prot_mode(prot_mode),
		.rsp_valid(rsp_valid), .rsp_denied(rsp_denied), .rsp_rdata(rsp_rdata));
	fbep_req_model u_fbep_req_model (.ref_clk(ref_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_denied(rsp_denied), .rsp_rdata(rsp_rdata), .req_valid(req_valid), .req_kind(req_kind),
		.req_addr(req_addr), .req_wdata(req_wdata));
	// Clock at 250 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Step the shift register
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cmp_flag(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask
	task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One request through design and model
	task automatic run(input logic [2:0] k, input logic [13:0] a);
		logic [1:0] p;
		logic e;
		int w;
		lfsr = nxt(lfsr);
		p = prot_mode[a[13:11]*2 +: 2];
		w = int'(a[13:2]);
		e = k > 3'h4 || (k >= 3'h3 && p != 2'h0) || ((k == 3'h1 || k == 3'h2) && p[1]);
		u_fbep_req_model.issue(k, a, {lfsr, ~lfsr}, den, rd);
		cmp_flag(den, e);
		if (e) cmp_word(rd, 32'h0);
		else if (k == 3'h3) mem[w] = {lfsr, ~lfsr};
		else if (k == 3'h4) for (int i = 0; i < 256; i++) mem[int'({a[13:10], 8'h00}) + i] = 32'hFFFFFFFF;
		else if (mem.exists(w)) cmp_word(rd, mem[w]);
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		prot_mode = 16'h0000;
		repeat (16) @(negedge ref_clk);
		arst_n = 1'b1;
		@(negedge ref_clk);
		// Erase every block, then one block beside a programmed word
		for (int b = 0; b < 16; b++) run(3'h4, 14'(b * 1024));
		run(3'h3, 14'h0400);
		run(3'h4, 14'h0000);
		run(3'h0, 14'h03FC);
		run(3'h2, 14'h0400);
		// Every code with every kind, other units random
		for (int r = 0; r < 2; r++) begin
			for (int m = 0; m < 4; m++) begin
				for (int k = 0; k < 8; k++) begin
					prot_mode = {lfsr[7:0], ~lfsr[15:8]};
					ra = lfsr[13:0];
					prot_mode[ra[13:11]*2 +: 2] = 2'(m);
					run(3'(k), {ra[13:2], 2'h0});
				end
			end
		end
		end_sim;
	end
	// Cut a hang short
	initial begin
		#100000;
		n_mismatch++;
		end_sim;
	end
endmodule
